// ---- logic/cmp_ctl_pkg.sv ----
// Purpose: Shared constants, types and mode decoding for the comparator control block
// Assumes: Analog levels arrive as digitised codes on the core clock
// Notes: One byte-wide register port, read data in the cycle after the read strobe
`default_nettype none
package cmp_ctl_pkg;
    localparam int unsigned ANA_W = 10;
    // Register offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] CFG2_OFS = 8'h01;
    localparam logic [7:0] IRQ_OFS = 8'h02;
    // Values after reset
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG2_RESET = 8'h02;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    // Field positions in the configuration register
    localparam int unsigned CFG_RESULT_BIT = 6;
    localparam int unsigned CFG_INVERT_BIT = 4;
    localparam int unsigned CFG_SWITCH_BIT = 3;
    // Field positions in the second configuration register
    localparam int unsigned CFG2_SYNC_BIT = 0;
    localparam int unsigned CFG2_GATE_BIT = 1;
    // Field positions in the interrupt control register
    localparam int unsigned IRQ_FLAG_BIT = 0;
    localparam int unsigned IRQ_CMPEN_BIT = 1;
    localparam int unsigned IRQ_PEREN_BIT = 2;
    localparam int unsigned IRQ_GLBEN_BIT = 3;

    // Comparator mode field encodings
    typedef enum logic [2:0] {
        MODE_RESET = 3'h0,
        MODE_PIN_OUT = 3'h1,
        MODE_PIN_INT = 3'h2,
        MODE_REF_OUT = 3'h3,
        MODE_REF_INT = 3'h4,
        MODE_MUX_INT = 3'h5,
        MODE_MUX_OUT = 3'h6,
        MODE_OFF = 3'h7
    } cmp_mode_t;

    // Sleep and wake sequencing; one bit changes per step, except two on the step back to run
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STEP = 2'b11
    } wake_state_t;

    // Digitised analog levels
    typedef struct packed {
        logic [ANA_W-1:0] pos_input_pin;
        logic [ANA_W-1:0] neg_input_pin;
        logic [ANA_W-1:0] internal_ref_voltage;
    } ana_in_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Pin configuration towards the port logic
    typedef struct packed {
        logic pos_analog;
        logic neg_analog;
        logic out_pin_drive;
    } pin_cfg_t;

    function automatic logic mode_is_off(input cmp_mode_t m);
        return (m == MODE_RESET) || (m == MODE_OFF);
    endfunction

    function automatic logic mode_is_mux(input cmp_mode_t m);
        return (m == MODE_MUX_INT) || (m == MODE_MUX_OUT);
    endfunction

    // Declared after the mux test so that no call reaches forward
    function automatic logic mode_uses_ref(input cmp_mode_t m);
        return (m == MODE_REF_OUT) || (m == MODE_REF_INT) || mode_is_mux(m);
    endfunction

    function automatic logic mode_drives_pin(input cmp_mode_t m);
        return (m == MODE_PIN_OUT) || (m == MODE_REF_OUT) || (m == MODE_MUX_OUT);
    endfunction
endpackage
`default_nettype wire

// ---- logic/cmp_core.sv ----
// Purpose: Input routing, comparison and output polarity of the comparator
// Assumes: Level codes are stable on the core clock
// Notes: Equal levels keep the previous decision, acting as a tiny hysteresis
`default_nettype none
module cmp_core
    import cmp_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire cmp_mode_t mode_i,
    input wire logic out_invert_i,
    input wire logic input_switch_i,
    input wire ana_in_t ana_i,
    output logic raw_o,
    output logic result_o
);
    logic [ANA_W-1:0] noninv_input;
    logic [ANA_W-1:0] inv_input;
    logic next_raw;

    // Route pins or the reference to the two comparator inputs
    always_comb
    begin
        noninv_input = ana_i.pos_input_pin;
        inv_input = ana_i.neg_input_pin;
        if (mode_uses_ref(mode_i))
        begin
            noninv_input = ana_i.internal_ref_voltage;
        end
        if (mode_is_mux(mode_i) && input_switch_i)
        begin
            inv_input = ana_i.pos_input_pin;
        end
    end

    // Decision; off modes park the comparator low
    always_comb
    begin
        next_raw = raw_o;
        if (mode_is_off(mode_i))
        begin
            next_raw = 1'b0;
        end
        else if (noninv_input > inv_input)
        begin
            next_raw = 1'b1;
        end
        else if (noninv_input < inv_input)
        begin
            next_raw = 1'b0;
        end
    end

    // Raw and polarity-adjusted result
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            raw_o <= 1'b0;
            result_o <= 1'b0;
        end
        else
        begin
            raw_o <= next_raw;
            result_o <= mode_is_off(mode_i) ? 1'b0 : (next_raw ^ out_invert_i);
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_raw_high;
        (!mode_is_off(mode_i) && noninv_input > inv_input) |=> raw_o;
    endproperty
    a_raw_high: assert property (p_raw_high) else $error("raw not high");

    property p_raw_low;
        (!mode_is_off(mode_i) && noninv_input < inv_input) |=> !raw_o;
    endproperty
    a_raw_low: assert property (p_raw_low) else $error("raw not low");

    property p_polarity;
        !mode_is_off($past(mode_i)) |-> result_o == (raw_o ^ $past(out_invert_i));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_switch;
        (mode_is_mux(mode_i) && input_switch_i
            && ana_i.internal_ref_voltage > ana_i.pos_input_pin) |=> raw_o;
    endproperty
    a_switch: assert property (p_switch) else $error("switch route wrong");

    property p_ref;
        (mode_uses_ref(mode_i) && !input_switch_i
            && ana_i.internal_ref_voltage < ana_i.neg_input_pin) |=> !raw_o;
    endproperty
    a_ref: assert property (p_ref) else $error("reference route wrong");
endmodule
`default_nettype wire

// ---- logic/comparator_control_logic.sv ----
// Purpose: Control, status, change flag and wake-up logic around one comparator
// Assumes: Core raises sleep_i while asleep and pulses instr_done_i per instruction
// Notes: Register reads return data in the cycle after the strobe, zero otherwise
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module comparator_control_logic
    import cmp_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire ana_in_t ana_i,
    input wire logic sleep_i,
    input wire logic instr_done_i,
    output logic wake_o,
    output logic irq_req_o,
    output logic cmp_result_o,
    output logic cmp_out_pin_o,
    output logic cmp_out_pin_oe_n_o,
    output pin_cfg_t pin_cfg_o,
    output logic timer_gate_source_sel_o,
    output logic output_sync_sel_o
);
    cmp_mode_t cmp_mode_sel;
    logic out_invert;
    logic input_switch;
    logic timer_gate_source_sel;
    logic output_sync_sel;
    logic cmp_irq_enable;
    logic periph_irq_enable;
    logic global_irq_enable;
    logic cmp_change_flag;
    logic raw;
    logic result;
    logic prev_result;
    logic change;
    logic wake_cond;
    logic wr_cfg;
    logic wr_cfg2;
    logic wr_irq;
    logic [7:0] cfg_view;
    logic [7:0] cfg2_view;
    logic [7:0] irq_view;
    logic [7:0] next_rdata;
    wake_state_t state;
    wake_state_t next_state;

    // Write decode
    assign wr_cfg = req_i.wr && (req_i.addr == CFG_OFS);
    assign wr_cfg2 = req_i.wr && (req_i.addr == CFG2_OFS);
    assign wr_irq = req_i.wr && (req_i.addr == IRQ_OFS);

    // The comparator itself runs regardless of sleep state
    cmp_core u_core (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .mode_i(cmp_mode_sel),
        .out_invert_i(out_invert),
        .input_switch_i(input_switch),
        .ana_i(ana_i),
        .raw_o(raw),
        .result_o(result)
    );

    // Configuration register; status bit is not writable
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmp_mode_sel <= MODE_RESET;
            out_invert <= CFG_RESET[CFG_INVERT_BIT];
            input_switch <= CFG_RESET[CFG_SWITCH_BIT];
        end
        else if (wr_cfg)
        begin
            cmp_mode_sel <= cmp_mode_t'(req_i.wdata[2:0]);
            out_invert <= req_i.wdata[CFG_INVERT_BIT];
            input_switch <= req_i.wdata[CFG_SWITCH_BIT];
        end
    end

    // Second configuration register, held for the timer and sync logic
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            timer_gate_source_sel <= CFG2_RESET[CFG2_GATE_BIT];
            output_sync_sel <= CFG2_RESET[CFG2_SYNC_BIT];
        end
        else if (wr_cfg2)
        begin
            timer_gate_source_sel <= req_i.wdata[CFG2_GATE_BIT];
            output_sync_sel <= req_i.wdata[CFG2_SYNC_BIT];
        end
    end

    // Interrupt enables
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmp_irq_enable <= IRQ_RESET[IRQ_CMPEN_BIT];
            periph_irq_enable <= IRQ_RESET[IRQ_PEREN_BIT];
            global_irq_enable <= IRQ_RESET[IRQ_GLBEN_BIT];
        end
        else if (wr_irq)
        begin
            cmp_irq_enable <= req_i.wdata[IRQ_CMPEN_BIT];
            periph_irq_enable <= req_i.wdata[IRQ_PEREN_BIT];
            global_irq_enable <= req_i.wdata[IRQ_GLBEN_BIT];
        end
    end

    // Previous result, for change detection
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prev_result <= 1'b0;
        end
        else
        begin
            prev_result <= result;
        end
    end

    assign change = result != prev_result;

    // Change flag: a change in the clearing cycle wins, so no edge is lost
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmp_change_flag <= IRQ_RESET[IRQ_FLAG_BIT];
        end
        else if (change)
        begin
            cmp_change_flag <= 1'b1;
        end
        else if (wr_irq && !req_i.wdata[IRQ_FLAG_BIT])
        begin
            cmp_change_flag <= 1'b0;
        end
    end

    // Wake needs both enables; the global enable only gates the vector
    assign wake_cond = cmp_change_flag && cmp_irq_enable && periph_irq_enable;

    // Sleep sequencing: the step state holds the vector off for one instruction
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RUN:
            begin
                if (sleep_i)
                begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (wake_cond)
                begin
                    next_state = ST_STEP;
                end
            end
            ST_STEP:
            begin
                if (instr_done_i)
                begin
                    next_state = ST_RUN;
                end
            end
            default:
            begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Wake pulse and vector request
    assign wake_o = (state == ST_SLEEP) && wake_cond;
    assign irq_req_o = (state == ST_RUN) && wake_cond && global_irq_enable;

    // Pin configuration; reset mode leaves every pin analog
    always_comb
    begin
        pin_cfg_o.neg_analog = cmp_mode_sel != MODE_OFF;
        pin_cfg_o.pos_analog = !mode_uses_ref(cmp_mode_sel) || mode_is_mux(cmp_mode_sel);
        if (cmp_mode_sel == MODE_OFF)
        begin
            pin_cfg_o.pos_analog = 1'b0;
        end
        pin_cfg_o.out_pin_drive = mode_drives_pin(cmp_mode_sel);
    end

    // Output pin and plain outputs
    assign cmp_out_pin_o = result;
    assign cmp_out_pin_oe_n_o = !mode_drives_pin(cmp_mode_sel);
    assign cmp_result_o = result;
    assign timer_gate_source_sel_o = timer_gate_source_sel;
    assign output_sync_sel_o = output_sync_sel;

    // Read views; unused bits read as zero
    assign cfg_view = {1'b0, result, 1'b0, out_invert, input_switch, cmp_mode_sel};
    assign cfg2_view = {6'h00, timer_gate_source_sel, output_sync_sel};
    assign irq_view = {4'h0, global_irq_enable, periph_irq_enable, cmp_irq_enable,
        cmp_change_flag};

    always_comb
    begin
        next_rdata = 8'h00;
        if (req_i.rd)
        begin
            unique case (req_i.addr)
                CFG_OFS: next_rdata = cfg_view;
                CFG2_OFS: next_rdata = cfg2_view;
                IRQ_OFS: next_rdata = irq_view;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= next_rdata;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_status_read;
        (req_i.rd && req_i.addr == CFG_OFS) |=> rdata_o[CFG_RESULT_BIT] == $past(result);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit wrong");

    property p_status_ro;
        (wr_cfg && req_i.wdata[CFG_RESULT_BIT] && mode_is_off(cmp_mode_t'(req_i.wdata[2:0])))
            |=>
            ##1 !result;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status bit writable");

    property p_off_quiet;
        mode_is_off(cmp_mode_sel) [*2] |-> !result && !raw;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off mode active");

    property p_sleep_update;
        (state == ST_SLEEP && change) |=> cmp_change_flag;
    endproperty
    a_sleep_update: assert property (p_sleep_update) else $error("no update in sleep");

    // Without both enables the sleep state must hold and no wake pulse appear
    property p_wake_gate;
        (state == ST_SLEEP && !(cmp_irq_enable && periph_irq_enable) && !req_i.wr) |=>
            state == ST_SLEEP && !wake_o;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake without enables");

    property p_wake_seen;
        (state == ST_SLEEP && wake_cond) |-> wake_o ##1 state == ST_STEP;
    endproperty
    a_wake_seen: assert property (p_wake_seen) else $error("wake missed");

    // The step state waits for the instruction and keeps the vector off
    property p_step_hold;
        (state == ST_STEP && !instr_done_i) |=> state == ST_STEP && !irq_req_o;
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("vector before step");

    property p_step_vector;
        (state == ST_STEP && instr_done_i && wake_cond && global_irq_enable
            && !req_i.wr && !sleep_i) |=> irq_req_o;
    endproperty
    a_step_vector: assert property (p_step_vector) else $error("vector not taken");

    property p_reset_state;
        $past(rst_i) |-> cmp_mode_sel == MODE_RESET && !out_invert && !input_switch
            && {timer_gate_source_sel, output_sync_sel} == CFG2_RESET[1:0];
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset value wrong");

    property p_reset_pins;
        (cmp_mode_sel == MODE_RESET) |-> pin_cfg_o.pos_analog && pin_cfg_o.neg_analog
            && cmp_out_pin_oe_n_o;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("reset mode pins");

    property p_flag_set;
        change |=> cmp_change_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_clear;
        (wr_irq && !req_i.wdata[IRQ_FLAG_BIT] && !change) |=> !cmp_change_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    c_wake: cover property (state == ST_SLEEP ##1 wake_o ##[1:20] state == ST_RUN);
    c_irq: cover property (state == ST_STEP ##1 irq_req_o);
    c_clear_race: cover property (change && wr_irq && !req_i.wdata[IRQ_FLAG_BIT]);
endmodule
`default_nettype wire

// ---- testbench/analog_source.sv ----
// Purpose: Far-side model of the two analog pins and the internal reference
// Assumes: Levels are digitised codes that change only just after a rising edge
// Notes: Levels hold until the bench asks for new ones; no noise is modelled
`default_nettype none
module analog_source
    import cmp_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    output var ana_in_t ana_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins start near mid-scale and the reference at quarter scale, so no input sits at a rail
    initial
    begin
        ana_o = '{10'h200, 10'h1ff, 10'h100};
    end

    // New levels land together, so no false crossing appears between them
    task automatic set_levels(input logic [ANA_W-1:0] p, input logic [ANA_W-1:0] n,
                              input logic [ANA_W-1:0] r);
        @(posedge ref_clk_i);
        ana_o.pos_input_pin <= p;
        ana_o.neg_input_pin <= n;
        ana_o.internal_ref_voltage <= r;
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the comparator control block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Two level sets expose routing, reference and switch choices
`default_nettype none
module testbench
    import cmp_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i = 1'b0;
    logic rst_i;
    reg_req_t req;
    logic [7:0] rdata;
    ana_in_t ana;
    logic sleep, instr_done, wake, irq_req, res, pin, oe_n, tgs, sync;
    pin_cfg_t pcfg;
    logic [9:0] lp, ln, lr;
    int n_fail, n_tests, cycles, wake_cnt;

    analog_source analog_source_inst (.ref_clk_i(ref_clk_i), .ana_o(ana));

    comparator_control_logic comparator_control_logic_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .ana_i(ana),
        .sleep_i(sleep), .instr_done_i(instr_done), .wake_o(wake), .irq_req_o(irq_req),
        .cmp_result_o(res), .cmp_out_pin_o(pin), .cmp_out_pin_oe_n_o(oe_n),
        .pin_cfg_o(pcfg), .timer_gate_source_sel_o(tgs), .output_sync_sel_o(sync));

    always #4 ref_clk_i = ~ref_clk_i;

    // Cycle ceiling and wake pulse counting; whole run needs under 1500 cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (wake === 1'b1)
            wake_cnt++;
        if (cycles == 5000)
        begin
            n_fail++;
            $display("ERROR at %0t: run did not complete", $time);
            finish_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic set_lv(input logic [9:0] p, input logic [9:0] n, input logic [9:0] r);
        lp = p;
        ln = n;
        lr = r;
        analog_source_inst.set_levels(p, n, r);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        logic [2:0] md;
        logic sw, inv, raw, rs, pa, na, dr;
        logic [9:0] nv, iv;
        req = '0;
        sleep = 1'b0;
        instr_done = 1'b0;
        rst_i = 1'b1;
        n_fail = 0;
        n_tests = 0;
        cycles = 0;
        wake_cnt = 0;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // Reset state and an unmapped place
        reg_rd(CFG_OFS, CFG_RESET);
        reg_rd(CFG2_OFS, CFG2_RESET);
        reg_rd(IRQ_OFS, IRQ_RESET);
        reg_rd(8'h05, 8'h00);
        check({5'h00, pcfg}, 8'h06);
        check({7'h00, res}, 8'h00);
        check({6'h00, tgs, sync}, 8'h02);
        $display("test reset finished");
        // Sweep every mode, switch and polarity over two level sets
        for (int s = 0; s < 2; s++)
        begin
            if (s == 0)
                set_lv(10'd300, 10'd200, 10'd150);
            else
                set_lv(10'd100, 10'd200, 10'd150);
            for (int m = 0; m < 8; m++)
            begin
                for (int k = 0; k < 4; k++)
                begin
                    md = m[2:0];
                    sw = k[0];
                    inv = k[1];
                    nv = (md >= 3'h3 && md <= 3'h6) ? lr : lp;
                    iv = ((md == 3'h5 || md == 3'h6) && sw) ? lp : ln;
                    raw = (nv > iv);
                    rs = (md == 3'h0 || md == 3'h7) ? 1'b0 : raw ^ inv;
                    pa = md inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
                    na = (md != 3'h7);
                    dr = md inside {3'h1, 3'h3, 3'h6};
                    reg_wr(CFG_OFS, {3'b000, inv, sw, md});
                    tick(2);
                    check({7'h00, res}, {7'h00, rs});
                    check({7'h00, pin}, {7'h00, rs});
                    check({5'h00, pcfg}, {5'h00, pa, na, dr});
                    check({7'h00, oe_n}, {7'h00, ~dr});
                    reg_rd(CFG_OFS, {1'b0, rs, 1'b0, inv, sw, md});
                end
            end
        end
        // Bits 7, 6 and 5 ignore writes; mode 111 stays off
        reg_wr(CFG_OFS, 8'hff);
        tick(2);
        reg_rd(CFG_OFS, 8'h1f);
        $display("test mode sweep finished");
        // Change flag, its clearing and the enable gating
        reg_wr(CFG_OFS, 8'h02);
        set_lv(10'd300, 10'd200, 10'd150);
        tick(3);
        reg_wr(IRQ_OFS, 8'h0e);
        tick(2);
        reg_rd(IRQ_OFS, 8'h0e);
        check({7'h00, irq_req}, 8'h00);
        set_lv(10'd100, 10'd200, 10'd150);
        tick(3);
        reg_rd(IRQ_OFS, 8'h0f);
        check({7'h00, irq_req}, 8'h01);
        reg_wr(IRQ_OFS, 8'h0b);
        tick(1);
        check({7'h00, irq_req}, 8'h00);
        reg_rd(IRQ_OFS, 8'h0b);
        reg_wr(IRQ_OFS, 8'h0e);
        reg_rd(IRQ_OFS, 8'h0e);
        // A change landing in the clearing cycle keeps the flag set
        set_lv(10'd300, 10'd200, 10'd150);
        reg_wr(IRQ_OFS, 8'h0e);
        reg_rd(IRQ_OFS, 8'h0f);
        set_lv(10'd100, 10'd200, 10'd150);
        tick(3);
        $display("test change flag finished");
        // Sleep: no wake without the peripheral enable, still updating
        reg_wr(IRQ_OFS, 8'h02);
        @(posedge ref_clk_i);
        sleep <= 1'b1;
        tick(1);
        wake_cnt = 0;
        set_lv(10'd300, 10'd200, 10'd150);
        tick(4);
        check(wake_cnt[7:0], 8'h00);
        reg_rd(CFG_OFS, 8'h42);
        // Both enables: one wake, then one instruction before service
        reg_wr(IRQ_OFS, 8'h0e);
        tick(1);
        wake_cnt = 0;
        set_lv(10'd100, 10'd200, 10'd150);
        tick(4);
        check(wake_cnt[7:0], 8'h01);
        check({7'h00, irq_req}, 8'h00);
        @(posedge ref_clk_i);
        sleep <= 1'b0;
        tick(2);
        check({7'h00, irq_req}, 8'h00);
        @(posedge ref_clk_i);
        instr_done <= 1'b1;
        @(posedge ref_clk_i);
        instr_done <= 1'b0;
        #1;
        check({7'h00, irq_req}, 8'h01);
        $display("test sleep and wake finished");
        // Reset in mid-run restores both configuration registers
        reg_wr(CFG2_OFS, 8'h01);
        tick(1);
        check({6'h00, tgs, sync}, 8'h01);
        reg_wr(CFG_OFS, 8'h16);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        tick(3);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        reg_rd(CFG_OFS, CFG_RESET);
        reg_rd(CFG2_OFS, CFG2_RESET);
        check({5'h00, pcfg}, 8'h06);
        check({7'h00, oe_n}, 8'h01);
        $display("test second reset finished");
        finish_test();
    end
endmodule
`default_nettype wire
